// File: core/cpm_core.sv
// Function
// - 23-bit instruction pointer, bit zero zero
// - Sixteen 16-bit general working registers
// - Register fifteen is auto-updated stack pointer
// - Stack pointer loads fixed value at reset
// - Register fourteen is frame pointer, still general
// - Register zero is implicit accumulator operand
// - Datapath byte writes change only low byte
// - Core registers memory mapped, byte addressable
// - Fast shadow swaps W0-W3 and five flags
// - Loop start pushes loop registers, end pops
// - Status word 16 bits, two bytes
// - Low byte: ALU flags, priority, repeat
// - Exception stacks status low with IP high
// - High byte: DSP flags, loop, digit carry
// - Loop-active bit readable, clear-only by software
// - Repeat-active read-only, set on repeat entry
// - Overflow bits read-only, set by DSP
// - Saturation flags sticky, software clearable
// - Clearing combined saturation clears both
// - Status write suppressed when flags update
// - 62 vectors, traps 8-15, interrupts 1-7
`timescale 1ns/100ps
`default_nettype none

module cpm_core
  import cpm_pkg::*;
(
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_nrst,
  // Software data-space access
  input  wire cpm_dbus_t         i_dbus,
  output logic [15:0]            o_rdata,
  output logic                   o_hit,
  // Datapath register write and operand read
  input  wire cpm_wwr_t          i_wwr,
  input  wire logic [3:0]        i_rd_idx,
  output logic [15:0]            o_rd_data,
  output logic [15:0]            o_acc_operand,
  output logic [15:0]            o_frame_ptr,
  // Instruction pointer
  input  wire logic              i_ip_load,
  input  wire logic [22:0]       i_ip_next,
  output logic [22:0]            o_ip,
  // Stack events
  input  wire logic              i_call,
  input  wire logic              i_ret,
  input  wire logic              i_exc_enter,
  input  wire logic [2:0]        i_exc_ipl,
  output logic [15:0]            o_stack_ptr,
  output logic [15:0]            o_exc_word,
  // Shadows and loops
  input  wire logic              i_push_s,
  input  wire logic              i_pop_s,
  input  wire logic [15:0]       i_loop_start,
  input  wire logic [15:0]       i_loop_end,
  input  wire logic [15:0]       i_loop_cnt,
  // Status updates
  input  wire cpm_stat_t         i_stat,
  output logic [15:0]            o_status,
  // Exception priority of a request
  input  wire logic [5:0]        i_vec,
  input  wire logic [2:0]        i_irq_pri,
  output logic [3:0]             o_vec_pri,
  output logic                   o_vec_valid
);

  logic [15:0] wreg [WREG_N];        // Working register array
  logic [15:0] shadow_w [4];         // Hidden copies of W0-W3
  logic [15:0] shadow_st;            // Hidden copy of five flags
  logic [15:0] status;               // Status word
  logic [22:0] ip;                   // Instruction pointer
  logic [15:0] lp_start, lp_end, lp_cnt;     // Loop registers
  logic [15:0] lps_start, lps_end, lps_cnt;  // Their shadows

  // Tells whether a data-space address hits a working register
  function automatic logic is_wreg(input logic [15:0] a);
    return a < (WREG_BASE + 16'h0020);
  endfunction : is_wreg

  // Merges a byte or word write into an old value
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic bop, input logic hi);
    if (!bop)
      return nw;
    else if (hi)
      return {nw[7:0], old[7:0]};
    else
      return {old[15:8], nw[7:0]};
  endfunction : merge

  logic        bus_wreg_wr;          // Software write hits a working register
  logic [3:0]  bus_widx;             // Its index
  logic        bus_st_wr;            // Software write hits status
  logic        st_busy;              // Hardware updates status this cycle
  logic [15:0] sp_adj;               // Stack pointer after call or return

  assign bus_wreg_wr = i_dbus.wr && is_wreg(i_dbus.addr);
  assign bus_widx    = i_dbus.addr[4:1];
  assign bus_st_wr   = i_dbus.wr && (i_dbus.addr[15:1] == STATUS_A[15:1]);
  assign st_busy     = i_stat.alu_en | i_stat.ovf_en | i_stat.sat_a | i_stat.sat_b
                       | i_stat.rpt_enter | i_stat.rpt_exit | i_stat.loop_enter
                       | i_stat.loop_exit | i_pop_s | i_exc_enter;
  // Calls and exceptions push two words, returns pop two
  assign sp_adj = (i_call | i_exc_enter) ? wreg[STACK_IDX] + 16'h0004
                : wreg[STACK_IDX] - 16'h0004;

  // Working register array; four low registers also take shadow pops
  generate
    for (genvar g = 0; g < WREG_N; g++) begin : g_wreg
      always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          wreg[g] <= (g == STACK_IDX) ? STACK_RST : WREG_RST;
        end else if (g < 4 && i_pop_s) begin
          wreg[g] <= shadow_w[g];
        end else if (g == STACK_IDX && (i_call | i_ret | i_exc_enter)) begin
          wreg[g] <= {sp_adj[15:1], 1'b0};
        end else if (i_wwr.en && i_wwr.idx == 4'(g)) begin
          // Byte ops touch the low byte only
          wreg[g] <= merge(wreg[g], i_wwr.data, i_wwr.byte_op, 1'b0);
          if (g == STACK_IDX)
            wreg[g][0] <= 1'b0;
        end else if (bus_wreg_wr && bus_widx == 4'(g)) begin
          wreg[g] <= merge(wreg[g], i_dbus.wdata, i_dbus.byte_op, i_dbus.addr[0]);
          if (g == STACK_IDX)
            wreg[g][0] <= 1'b0;
        end
      end
    end
  endgenerate

  // Shadow copies for the fast push; not addressable
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int k = 0; k < 4; k++)
        shadow_w[k] <= WREG_RST;
      shadow_st <= STATUS_RST;
    end else if (i_push_s) begin
      for (int k = 0; k < 4; k++)
        shadow_w[k] <= wreg[k];
      shadow_st <= status & SHADOW_MASK;
    end
  end

  // Loop registers and their shadows
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lp_start  <= WREG_RST;
      lp_end    <= WREG_RST;
      lp_cnt    <= WREG_RST;
      lps_start <= WREG_RST;
      lps_end   <= WREG_RST;
      lps_cnt   <= WREG_RST;
    end else if (i_stat.loop_enter) begin
      // Old values saved so nested loops resume
      lps_start <= lp_start;
      lps_end   <= lp_end;
      lps_cnt   <= lp_cnt;
      lp_start  <= i_loop_start;
      lp_end    <= i_loop_end;
      lp_cnt    <= i_loop_cnt;
    end else if (i_stat.loop_exit) begin
      lp_start  <= lps_start;
      lp_end    <= lps_end;
      lp_cnt    <= lps_cnt;
    end else if (i_dbus.wr && i_dbus.addr[15:1] == LOOP_START_A[15:1]) begin
      lp_start  <= merge(lp_start, i_dbus.wdata, i_dbus.byte_op, i_dbus.addr[0]);
    end else if (i_dbus.wr && i_dbus.addr[15:1] == LOOP_END_A[15:1]) begin
      lp_end    <= merge(lp_end, i_dbus.wdata, i_dbus.byte_op, i_dbus.addr[0]);
    end else if (i_dbus.wr && i_dbus.addr[15:1] == LOOP_CNT_A[15:1]) begin
      lp_cnt    <= merge(lp_cnt, i_dbus.wdata, i_dbus.byte_op, i_dbus.addr[0]);
    end
  end

  // Instruction pointer; bit zero cannot be set
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst)
      ip <= IP_RST;
    else if (i_ip_load)
      ip <= {i_ip_next[22:1], 1'b0};
  end

  // Status word; hardware set wins over software clear
  logic [15:0] sw_val;               // Software write merged into old status
  logic [15:0] next_status;
  always_comb begin
    sw_val      = merge(status, i_dbus.wdata, i_dbus.byte_op, i_dbus.addr[0]);
    next_status = status;
    // Write disabled on every bit when hardware also updates status
    if (bus_st_wr && !st_busy) begin
      next_status = (status & ~SW_RW_MASK) | (sw_val & SW_RW_MASK);
      if (!sw_val[B_LOOP])   next_status[B_LOOP] = 1'b0;
      if (!sw_val[B_SA])     next_status[B_SA]   = 1'b0;
      if (!sw_val[B_SB])     next_status[B_SB]   = 1'b0;
      if (!sw_val[B_SAB]) begin
        next_status[B_SAB] = 1'b0;
        next_status[B_SA]  = 1'b0;
        next_status[B_SB]  = 1'b0;
      end
    end
    if (i_pop_s)
      next_status = (next_status & ~SHADOW_MASK) | shadow_st;
    if (i_stat.alu_en)
      next_status = (next_status & ~ALU_MASK) | (i_stat.alu_val & ALU_MASK);
    if (i_stat.ovf_en) begin
      next_status[B_OVF] = i_stat.ovf_int;
      next_status[B_OA]  = i_stat.ovf_a;
      next_status[B_OB]  = i_stat.ovf_b;
      next_status[B_OAB] = i_stat.ovf_a | i_stat.ovf_b;
    end
    if (i_stat.sat_a) next_status[B_SA] = 1'b1;
    if (i_stat.sat_b) next_status[B_SB] = 1'b1;
    if (i_stat.sat_a | i_stat.sat_b) next_status[B_SAB] = 1'b1;
    if (i_stat.rpt_exit)   next_status[B_RPT]  = 1'b0;
    if (i_stat.rpt_enter)  next_status[B_RPT]  = 1'b1;
    if (i_stat.loop_exit)  next_status[B_LOOP] = 1'b0;
    if (i_stat.loop_enter) next_status[B_LOOP] = 1'b1;
    if (i_exc_enter)
      next_status[B_IPL_LO +: 3] = i_exc_ipl;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst)
      status <= STATUS_RST;
    else
      status <= next_status;
  end

  // Word stacked on exception entry
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst)
      o_exc_word <= 16'h0000;
    else if (i_exc_enter)
      o_exc_word <= {1'b0, ip[22:16], status[7:0]};
  end

  // Software read mux; unmapped reads return zero
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 16'h0000;
      o_hit   <= 1'b0;
    end else begin
      o_hit   <= i_dbus.rd;
      o_rdata <= 16'h0000;
      if (i_dbus.rd) begin
        if (is_wreg(i_dbus.addr))
          o_rdata <= wreg[bus_widx];
        else if (i_dbus.addr[15:1] == STATUS_A[15:1])
          o_rdata <= status;
        else if (i_dbus.addr[15:1] == LOOP_START_A[15:1])
          o_rdata <= lp_start;
        else if (i_dbus.addr[15:1] == LOOP_END_A[15:1])
          o_rdata <= lp_end;
        else if (i_dbus.addr[15:1] == LOOP_CNT_A[15:1])
          o_rdata <= lp_cnt;
        else if (i_dbus.addr[15:1] == IP_LO_A[15:1])
          o_rdata <= ip[15:0];
        else if (i_dbus.addr[15:1] == IP_HI_A[15:1])
          o_rdata <= {9'h000, ip[22:16]};
      end
    end
  end

  // Exception vector priority: traps fixed, interrupts user set
  always_comb begin
    o_vec_valid = i_vec < 6'(VEC_TOTAL);
    if (i_vec < 6'(TRAP_N))
      o_vec_pri = TRAP_PRI_LO + i_vec[3:0];
    else if (i_irq_pri == 3'h0)
      o_vec_pri = 4'h0;
    else
      o_vec_pri = {1'b0, i_irq_pri};
  end

  assign o_rd_data     = wreg[i_rd_idx];
  assign o_acc_operand = wreg[IMPLICIT_IDX];
  assign o_frame_ptr   = wreg[FRAME_IDX];
  assign o_stack_ptr   = wreg[STACK_IDX];
  assign o_ip          = ip;
  assign o_status      = status;

  // Checks
  property p_sp_align;
    @(posedge i_ref_clk) disable iff (!i_nrst) wreg[STACK_IDX][0] == 1'b0;
  endproperty
  a_sp_align: assert property (p_sp_align) else $error("stack pointer odd");

  property p_ip_align;
    @(posedge i_ref_clk) disable iff (!i_nrst) ip[0] == 1'b0;
  endproperty
  a_ip_align: assert property (p_ip_align) else $error("ip odd");

  property p_call;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_call && !i_ret && !i_exc_enter) |=> wreg[STACK_IDX] == $past(wreg[STACK_IDX]) + 16'h0004;
  endproperty
  a_call: assert property (p_call) else $error("call did not bump sp");

  property p_sab_clr;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (bus_st_wr && !st_busy && !sw_val[B_SAB]) |=> !status[B_SA] && !status[B_SB];
  endproperty
  a_sab_clr: assert property (p_sab_clr) else $error("sab clear missed");

  property p_sat_sticky;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (status[B_SA] && !bus_st_wr) |=> status[B_SA];
  endproperty
  a_sat_sticky: assert property (p_sat_sticky) else $error("sa not sticky");

  property p_loop_noset;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (!status[B_LOOP] && !i_stat.loop_enter) |=> !status[B_LOOP];
  endproperty
  a_loop_noset: assert property (p_loop_noset) else $error("loop bit set");

  property p_rpt_ro;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (status[B_RPT] && !i_stat.rpt_exit) |=> status[B_RPT];
  endproperty
  a_rpt_ro: assert property (p_rpt_ro) else $error("repeat bit cleared");

  property p_st_suppress;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (bus_st_wr && i_stat.rpt_exit && !i_stat.alu_en && !i_stat.ovf_en && !i_pop_s
       && !i_exc_enter && !i_stat.sat_a && !i_stat.sat_b && !i_stat.rpt_enter
       && !i_stat.loop_enter && !i_stat.loop_exit)
      |=> status[15:5] == $past(status[15:5]);
  endproperty
  a_st_suppress: assert property (p_st_suppress) else $error("status write leaked");

  property p_shadow;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_push_s && !i_wwr.en && !bus_wreg_wr) ##1 (i_pop_s && !i_push_s) |=> wreg[0] == $past(wreg[0], 2);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow restore wrong");

  c_call:  cover property (@(posedge i_ref_clk) disable iff (!i_nrst) i_call ##1 i_ret);
  c_exc:   cover property (@(posedge i_ref_clk) disable iff (!i_nrst) i_exc_enter);
  c_sat:   cover property (@(posedge i_ref_clk) disable iff (!i_nrst) i_stat.sat_a ##[1:5] bus_st_wr);
  c_loop:  cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
                           i_stat.loop_enter ##[1:16] i_stat.loop_exit);

endmodule : cpm_core

`default_nettype wire

// File: shared/cpm_pkg.sv
package cpm_pkg;

  // Instruction pointer width; bit 0 always clear
  localparam int unsigned IP_W         = 23;
  localparam int unsigned WREG_W       = 16;
  localparam int unsigned WREG_N       = 16;
  localparam int unsigned WIDX_W       = 4;
  localparam int unsigned DADDR_W      = 16;

  // Fixed working register roles
  localparam logic [3:0] IMPLICIT_IDX  = 4'h0;
  localparam logic [3:0] FRAME_IDX     = 4'he;
  localparam logic [3:0] STACK_IDX     = 4'hf;

  // Values after reset
  localparam logic [15:0] STACK_RST    = 16'h0800;
  localparam logic [15:0] WREG_RST     = 16'h0000;
  localparam logic [15:0] STATUS_RST   = 16'h0000;
  localparam logic [22:0] IP_RST       = 23'h000000;

  // Memory map of core registers in data space (byte addresses)
  localparam logic [15:0] WREG_BASE    = 16'h0000;
  localparam logic [15:0] LOOP_START_A = 16'h0036;
  localparam logic [15:0] LOOP_END_A   = 16'h0038;
  localparam logic [15:0] LOOP_CNT_A   = 16'h003a;
  localparam logic [15:0] STATUS_A     = 16'h0042;
  localparam logic [15:0] IP_LO_A      = 16'h002e;
  localparam logic [15:0] IP_HI_A      = 16'h0030;

  // Status word bit positions
  localparam int unsigned B_CARRY      = 0;
  localparam int unsigned B_ZERO       = 1;
  localparam int unsigned B_OVF        = 2;
  localparam int unsigned B_NEG        = 3;
  localparam int unsigned B_RPT        = 4;
  localparam int unsigned B_IPL_LO     = 5;
  localparam int unsigned B_DC         = 8;
  localparam int unsigned B_LOOP       = 9;
  localparam int unsigned B_SAB        = 10;
  localparam int unsigned B_OAB        = 11;
  localparam int unsigned B_SB         = 12;
  localparam int unsigned B_SA         = 13;
  localparam int unsigned B_OB         = 14;
  localparam int unsigned B_OA         = 15;

  // Masks of bits by access class
  localparam logic [15:0] SW_RW_MASK   = 16'h01eb; // C Z N IPL DC; overflow stays read-only
  localparam logic [15:0] SHADOW_MASK  = 16'h010f; // DC N OV Z C
  localparam logic [15:0] ALU_MASK     = 16'h010f;

  // Exception structure
  localparam int unsigned VEC_TOTAL    = 62;
  localparam int unsigned TRAP_N       = 8;
  localparam int unsigned IRQ_N        = 54;
  localparam logic [3:0]  TRAP_PRI_LO  = 4'h8;
  localparam logic [3:0]  IRQ_PRI_MIN  = 4'h1;
  localparam logic [3:0]  IRQ_PRI_MAX  = 4'h7;

  // Data space access from software
  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic                 byte_op;
    logic [DADDR_W-1:0]   addr;
    logic [15:0]          wdata;
  } cpm_dbus_t;

  // Working register write from the datapath
  typedef struct packed {
    logic                 en;
    logic                 byte_op;
    logic [WIDX_W-1:0]    idx;
    logic [15:0]          data;
  } cpm_wwr_t;

  // Status updates from the execution units
  typedef struct packed {
    logic                 alu_en;
    logic [15:0]          alu_val;  // C Z OV N DC positions
    logic                 ovf_en;
    logic                 ovf_int;
    logic                 ovf_a;
    logic                 ovf_b;
    logic                 sat_a;
    logic                 sat_b;
    logic                 rpt_enter;
    logic                 rpt_exit;
    logic                 loop_enter;
    logic                 loop_exit;
  } cpm_stat_t;

endpackage : cpm_pkg

// File: test/cpu_core_programmer_model_tb.sv
`timescale 1ns/100ps
`default_nettype none

module cpu_core_programmer_model_tb
  import cpm_pkg::*;
;
  // Clock, reset and event pulses
  logic        i_ref_clk = 1'b0;
  logic        i_nrst    = 1'b0;
  logic [5:0]  ev        = 6'h00;  // Call, return, exception, push, pop, pointer load
  // Stimulus buses
  cpm_dbus_t   dbus      = '0;
  cpm_wwr_t    wwr       = '0;
  cpm_stat_t   stat      = '0;
  logic [3:0]  rd_idx    = 4'h0;
  logic [22:0] ip_next   = 23'h0;
  logic [2:0]  exc_ipl   = 3'h5;
  logic [15:0] lp [3]    = '{default: 16'h0};
  logic [5:0]  vec       = 6'h00;
  logic [2:0]  irq_pri   = 3'h0;
  // Observed outputs
  logic [15:0] rdata, rd_data, acc_op, frame_ptr, sp, exc_word, status;
  logic        hit, vec_valid;
  logic [22:0] ip;
  logic [3:0]  vec_pri;
  // Bench bookkeeping and expected state
  int          fails     = 0;
  int          n_tests   = 0;
  logic [15:0] w [16];
  logic [15:0] la [3];
  logic [15:0] d;
  logic [22:0] ipv;

  cpm_core dut_u (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_dbus(dbus), .o_rdata(rdata), .o_hit(hit),
    .i_wwr(wwr), .i_rd_idx(rd_idx), .o_rd_data(rd_data), .o_acc_operand(acc_op),
    .o_frame_ptr(frame_ptr), .i_ip_load(ev[5]), .i_ip_next(ip_next), .o_ip(ip),
    .i_call(ev[0]), .i_ret(ev[1]), .i_exc_enter(ev[2]), .i_exc_ipl(exc_ipl),
    .o_stack_ptr(sp), .o_exc_word(exc_word), .i_push_s(ev[3]), .i_pop_s(ev[4]),
    .i_loop_start(lp[0]), .i_loop_end(lp[1]), .i_loop_cnt(lp[2]), .i_stat(stat),
    .o_status(status), .i_vec(vec), .i_irq_pri(irq_pri), .o_vec_pri(vec_pri),
    .o_vec_valid(vec_valid)
  );

  // Free-running 50 MHz clock
  always #10 i_ref_clk = ~i_ref_clk;

  // Verdict and end of run, shared with the watchdog
  task automatic stop_test();
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // Single comparison point; case inequality so unknowns never match
  task automatic check(input logic [22:0] seen, input logic [22:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One data-space access, launched on a falling edge, taken on the next rising edge
  task automatic bus(input logic wr, input logic bop, input logic [15:0] a, input logic [15:0] dat);
    @(negedge i_ref_clk);
    dbus = {wr, ~wr, bop, a, dat};
    @(negedge i_ref_clk);
    dbus = '0;
  endtask : bus

  // Word read; data stands for one cycle after the taking edge
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    bus(1'b0, 1'b0, a, 16'h0000);
    check(hit, 1'b1);
    check(rdata, exp);
  endtask : rchk

  // One-cycle event pulse
  task automatic pulse(input int k);
    @(negedge i_ref_clk);
    ev[k] = 1'b1;
    @(negedge i_ref_clk);
    ev[k] = 1'b0;
  endtask : pulse

  // One-cycle status update from the execution units
  task automatic st(input cpm_stat_t s);
    @(negedge i_ref_clk);
    stat = s;
    @(negedge i_ref_clk);
    stat = '0;
  endtask : st

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #40000;
    fails++;
    stop_test();
  end

  // Main sequence
  initial begin
    void'($urandom(34));
    repeat (2) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    check(sp, STACK_RST);
    check(status, STATUS_RST);
    check(ip, IP_RST);
    // Random fill of the general registers through data space
    for (int i = 0; i < 15; i++) begin
      w[i] = 16'($urandom);
      bus(1'b1, 1'b0, WREG_BASE + 16'(2 * i), w[i]);
    end
    for (int i = 0; i < 15; i++) begin
      rd_idx = 4'(i);
      #1 check(rd_data, w[i]);
      rchk(WREG_BASE + 16'(2 * i), w[i]);
    end
    // Byte writes: datapath low byte, data-space high byte
    d = 16'($urandom);
    @(negedge i_ref_clk) wwr = '{en: 1'b1, byte_op: 1'b1, idx: FRAME_IDX, data: d};
    @(negedge i_ref_clk) wwr = '0;
    w[14][7:0] = d[7:0];
    check(frame_ptr, w[14]);
    check(acc_op, w[0]);
    w[1][15:8] = d[15:8];
    bus(1'b1, 1'b1, 16'h0003, {8'h00, d[15:8]});
    rchk(16'h0002, w[1]);
    // Odd stack pointer is trimmed; calls and returns move it by one frame
    bus(1'b1, 1'b0, 16'h001e, 16'h1235);
    check(sp, 16'h1234);
    pulse(0);
    check(sp, 16'h1238);
    pulse(1);
    check(sp, 16'h1234);
    // Odd instruction pointer load comes out even
    ipv = 23'($urandom) | 23'h1;
    ip_next = ipv;
    pulse(5);
    ipv[0] = 1'b0;
    check(ip, ipv);
    // Status write masks read-only bits, then an exception stacks the word
    bus(1'b1, 1'b0, STATUS_A, 16'h00ff);
    check(status, 16'h00eb);
    pulse(2);
    check(exc_word, {1'b0, ipv[22:16], 8'heb});
    check(sp, 16'h1238);
    check(status[7:5], exc_ipl);
    bus(1'b1, 1'b0, STATUS_A, 16'h0000);
    bus(1'b1, 1'b0, STATUS_A, 16'hffff);
    check(status, 16'h01eb);
    bus(1'b1, 1'b1, STATUS_A + 16'h0001, 16'h0000);
    check(status, 16'h00eb);
    rchk(STATUS_A, 16'h00eb);
    // Overflow bits survive a software clear
    st('{ovf_en: 1'b1, ovf_int: 1'b1, ovf_a: 1'b1, default: '0});
    bus(1'b1, 1'b0, STATUS_A, 16'h0000);
    check({status[B_OA], status[B_OB], status[B_OVF]}, 3'b101);
    // Saturation is sticky; clearing the combined flag clears both
    st('{sat_a: 1'b1, sat_b: 1'b1, default: '0});
    st('{ovf_en: 1'b1, default: '0});
    check({status[B_SA], status[B_SB]}, 2'b11);
    bus(1'b1, 1'b0, STATUS_A, 16'h3800);
    check({status[B_SA], status[B_SB], status[B_SAB]}, 3'b000);
    st('{sat_a: 1'b1, default: '0});
    bus(1'b1, 1'b0, STATUS_A, 16'h0400);
    check(status[B_SA], 1'b0);
    // Repeat-active cannot be cleared by software
    st('{rpt_enter: 1'b1, default: '0});
    bus(1'b1, 1'b0, STATUS_A, 16'h0000);
    check(status[B_RPT], 1'b1);
    st('{rpt_exit: 1'b1, default: '0});
    // Nested loop entry pushes loop registers, exit restores them
    for (int k = 0; k < 3; k++) begin
      la[k] = 16'($urandom);
      lp[k] = la[k];
    end
    st('{loop_enter: 1'b1, default: '0});
    check(status[B_LOOP], 1'b1);
    for (int k = 0; k < 3; k++) lp[k] = 16'($urandom);
    st('{loop_enter: 1'b1, default: '0});
    for (int k = 0; k < 3; k++) rchk(LOOP_START_A + 16'(2 * k), lp[k]);
    // While the loop runs a written one leaves the bit alone, a zero clears it
    bus(1'b1, 1'b0, STATUS_A, 16'h0200);
    check(status[B_LOOP], 1'b1);
    bus(1'b1, 1'b0, STATUS_A, 16'h0000);
    check(status[B_LOOP], 1'b0);
    st('{loop_exit: 1'b1, default: '0});
    for (int k = 0; k < 3; k++) rchk(LOOP_START_A + 16'(2 * k), la[k]);
    bus(1'b1, 1'b0, STATUS_A, 16'h0200);
    check(status[B_LOOP], 1'b0);
    // Status write collides with a flag update: the whole write is dropped
    @(negedge i_ref_clk);
    dbus = {1'b1, 1'b0, 1'b0, STATUS_A, 16'h00e0};
    stat = '{alu_en: 1'b1, alu_val: 16'h0001, default: '0};
    @(negedge i_ref_clk);
    dbus = '0;
    stat = '0;
    check(status[7:5], 3'h0);
    check(status[B_CARRY], 1'b1);
    // Fast shadow round trip of W0-W3 and the shadowed flags
    for (int i = 0; i < 4; i++) begin
      w[i] = 16'($urandom);
      bus(1'b1, 1'b0, 16'(2 * i), w[i]);
    end
    st('{alu_en: 1'b1, alu_val: SHADOW_MASK, default: '0});
    pulse(3);
    for (int i = 0; i < 4; i++) bus(1'b1, 1'b0, 16'(2 * i), ~w[i]);
    st('{alu_en: 1'b1, alu_val: 16'h0000, default: '0});
    pulse(4);
    check(status & SHADOW_MASK, SHADOW_MASK);
    for (int i = 0; i < 4; i++) rchk(16'(2 * i), w[i]);
    // Push then pop on consecutive edges hands W0 back unchanged
    @(negedge i_ref_clk) ev[3] = 1'b1;
    @(negedge i_ref_clk) ev = 6'h10;
    @(negedge i_ref_clk) ev = 6'h00;
    check(acc_op, w[0]);
    // Mid-run reset brings back the values after reset
    @(negedge i_ref_clk) i_nrst = 1'b0;
    @(negedge i_ref_clk) i_nrst = 1'b1;
    check(sp, STACK_RST);
    check(status, STATUS_RST);
    // Every vector number, traps first, with random interrupt levels
    for (int v = 0; v < 64; v++) begin
      @(negedge i_ref_clk);
      vec = 6'(v);
      irq_pri = 3'($urandom_range(7, 0));
      #1;
      check(vec_valid, v < VEC_TOTAL);
      if (v < TRAP_N) check(vec_pri, 4'(TRAP_PRI_LO + v));
      else if (v < VEC_TOTAL) check(vec_pri, {1'b0, irq_pri});
    end
    stop_test();
  end

endmodule : cpu_core_programmer_model_tb

`default_nettype wire
